// *** acp_config_regs.sv ***
// acp_config_regs: power-down mask, alignment/reference/clock control and front-end
// option registers behind the serial configuration port, plus their decode.
// assumes serial clock well below sys_clk/4; all pins are asynchronous.
// Operation
// - mask bit 3 set keeps sampling clock buffer alive in global sleep unless single-ended clock is selected
// - mask bit 2 set keeps reference amplifier alive in global sleep
// - mask bit 1 set turns bandgap off in global sleep
// - control bit 7 picks pin role: sleep when clear, alignment when set
// - toggling control bit 6 issues alignment while register alignment enabled
// - alignment command bit holds its written value; host clears it
// - control bit 5 takes alignment from register bit, not the pin
// - control bit 3 hands reference choice from pin to register and enables register clock choice
// - reference field: 00 internal, 01 buffered external, 10 external direct
// - control bit 0 under register control selects single-ended clock input
// - option bit 5 makes channel A input single-ended
// - option bit 4 makes channel B input single-ended
// - option bit 2 stops delay loop, fastest grade only, below 40 MSPS
// - option bit 0 enables auto-zero; reset value depends on grade
// - global sleep from register bit or pin in its sleep role; the mask gates only the block power-downs
`timescale 1ns/100ps
`default_nettype none

module acp_config_regs
  import acp_pkg::*;
#(
  parameter bit FASTEST_GRADE = 1'b1
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // serial configuration port
  input  wire logic       cfg_sclk,
  input  wire logic       cfg_sen_n,
  input  wire logic       cfg_sdin,
  output logic            cfg_sdout,
  output logic            cfg_sdout_oe,
  // device pins and neighbouring register bit
  input  wire logic       align_or_sleep_pin,
  input  wire logic       reference_buffer_pin,
  input  wire logic       global_sleep_bit,
  // analog control outputs
  output logic            global_sleep,
  output logic            clock_buffer_off,
  output logic            reference_amp_off,
  output logic            bandgap_off,
  output logic            align_cmd,
  output logic [1:0]      reference_select,
  output logic            single_ended_clock_select,
  output logic            single_ended_input_chan_a,
  output logic            single_ended_input_chan_b,
  output logic            sampling_delay_loop_off,
  output logic            auto_zero_enable
);
  import acp_pkg::*;

  localparam logic [7:0] FE_RST = FASTEST_GRADE ? ACP_RST_FE_OPT_FAST : ACP_RST_FE_OPT_SLOW;

  logic           sclk_s, sen_n_s, sdin_s, pin_s, refpin_s;
  logic           sclk_d_ff, sen_n_d_ff, pin_d_ff, align_prev_ff;
  logic           nxt_sclk_d, nxt_sen_n_d, nxt_pin_d, nxt_align_prev;
  acp_spi_state_e state_ff, nxt_state;
  logic [3:0]     cnt_ff, nxt_cnt;
  logic [7:0]     shin_ff, nxt_shin, hdr_ff, nxt_hdr, shout_ff, nxt_shout;
  logic           sdout_ff, nxt_sdout, oe_ff, nxt_oe;
  logic [7:0]     mask_ff, nxt_mask, align_ff, nxt_align, fe_ff, nxt_fe;
  logic [7:0]     rx_byte, rdata;
  logic           sclk_rise, sclk_fall, frame_start, wr_commit;

  // ==========================================================================
  // pin synchronisers
  acp_sync2 #(.WIDTH(5)) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .din     ({cfg_sclk, cfg_sen_n, cfg_sdin, align_or_sleep_pin, reference_buffer_pin}),
    .dout    ({sclk_s, sen_n_s, sdin_s, pin_s, refpin_s})
  );

  assign sclk_rise   = sclk_s & ~sclk_d_ff;
  assign sclk_fall   = ~sclk_s & sclk_d_ff;
  assign frame_start = sen_n_d_ff & ~sen_n_s;
  assign rx_byte     = {shin_ff[6:0], sdin_s};

  // read mux; unmapped addresses read as zero
  always_comb begin
    unique case (rx_byte[6:0])
      ACP_ADDR_PDN_MASK:  rdata = mask_ff;
      ACP_ADDR_ALIGN_CTL: rdata = align_ff;
      ACP_ADDR_FE_OPT:    rdata = fe_ff;
      default:            rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // serial receiver and register file: next values
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_shin   = shin_ff;
    nxt_hdr    = hdr_ff;
    nxt_shout  = shout_ff;
    nxt_sdout  = sdout_ff;
    nxt_oe     = oe_ff;
    nxt_mask   = mask_ff;
    nxt_align  = align_ff;
    nxt_fe     = fe_ff;
    wr_commit  = 1'b0;
    unique case (state_ff)
      ACP_ST_IDLE: begin
        if (frame_start) begin
          nxt_state = ACP_ST_HDR;
          nxt_cnt   = 4'h0;
        end
      end
      ACP_ST_HDR: begin
        if (sclk_rise) begin
          nxt_shin = rx_byte;
          nxt_cnt  = cnt_ff + 4'h1;
          if (cnt_ff == ACP_LAST_BIT) begin
            nxt_state = ACP_ST_DATA;
            nxt_hdr   = rx_byte;
            nxt_cnt   = 4'h0;
            nxt_shout = rdata;
            nxt_oe    = rx_byte[ACP_RW_POS];
          end
        end
      end
      ACP_ST_DATA: begin
        // read data changes on the falling edge so the host samples it rising
        if (sclk_fall && oe_ff) begin
          nxt_sdout = shout_ff[7];
          nxt_shout = {shout_ff[6:0], 1'b0};
        end
        if (sclk_rise) begin
          nxt_shin = rx_byte;
          nxt_cnt  = cnt_ff + 4'h1;
          if (cnt_ff == ACP_LAST_BIT) begin
            nxt_state = ACP_ST_IDLE;
            nxt_oe    = 1'b0;
            wr_commit = ~hdr_ff[ACP_RW_POS];
          end
        end
      end
    endcase
    // reserved bits are stored as written, with no side effect
    if (wr_commit) begin
      if (hdr_ff[6:0] == ACP_ADDR_PDN_MASK) nxt_mask = rx_byte;
      if (hdr_ff[6:0] == ACP_ADDR_ALIGN_CTL) nxt_align = rx_byte;
      if (hdr_ff[6:0] == ACP_ADDR_FE_OPT) nxt_fe = rx_byte;
    end
    // deselect aborts a frame; a partial write is dropped
    if (sen_n_s) begin
      nxt_state = ACP_ST_IDLE;
      nxt_oe    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ACP_ST_IDLE;
      cnt_ff   <= 4'h0;
      shin_ff  <= 8'h00;
      hdr_ff   <= 8'h00;
      shout_ff <= 8'h00;
      sdout_ff <= 1'b0;
      oe_ff    <= 1'b0;
      mask_ff  <= ACP_RST_PDN_MASK;
      align_ff <= ACP_RST_ALIGN_CTL;
      fe_ff    <= FE_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      shin_ff  <= nxt_shin;
      hdr_ff   <= nxt_hdr;
      shout_ff <= nxt_shout;
      sdout_ff <= nxt_sdout;
      oe_ff    <= nxt_oe;
      mask_ff  <= nxt_mask;
      align_ff <= nxt_align;
      fe_ff    <= nxt_fe;
    end
  end

  assign cfg_sdout    = sdout_ff;
  assign cfg_sdout_oe = oe_ff;

  // ==========================================================================
  // control decode: next values
  logic       n_sleep, n_clkoff, n_refoff, n_bgoff, n_align, n_sec, n_sea, n_seb;
  logic       n_dll, n_az;
  logic [1:0] n_ref;
  logic       reg_ctl;

  always_comb begin
    nxt_sclk_d     = sclk_s;
    nxt_sen_n_d    = sen_n_s;
    nxt_pin_d      = pin_s;
    nxt_align_prev = align_ff[ACP_REG_ALIGN_POS];
    reg_ctl        = align_ff[ACP_REFERENCE_REGISTER_CONTROL_POS];
    n_sleep  = global_sleep_bit | (pin_s & ~align_ff[ACP_PIN_ALIGN_POS]);
    n_clkoff = n_sleep & ~mask_ff[ACP_KEEP_CLKBUF_POS];
    n_refoff = n_sleep & ~mask_ff[ACP_KEEP_REFAMP_POS];
    n_bgoff  = n_sleep & mask_ff[ACP_BG_OFF_POS];
    // pin alignment is ignored once the register owns alignment
    if (align_ff[ACP_REG_ALIGN_EN]) begin
      n_align = align_ff[ACP_REG_ALIGN_POS] ^ align_prev_ff;
    end else begin
      n_align = align_ff[ACP_PIN_ALIGN_POS] & pin_s & ~pin_d_ff;
    end
    // without register control, the pin picks internal or buffered external
    if (reg_ctl) begin
      n_ref = align_ff[ACP_REF_SEL_HI:ACP_REF_SEL_LO];
    end else begin
      n_ref = refpin_s ? ACP_REF_EXT_BUFFER : ACP_REF_INTERNAL;
    end
    n_sec = reg_ctl & align_ff[ACP_SE_CLK_POS];
    // single-ended clock also stops the differential buffer
    n_clkoff = n_clkoff | n_sec;
    n_sea = fe_ff[ACP_SE_A_POS];
    n_seb = fe_ff[ACP_SE_B_POS];
    n_dll = FASTEST_GRADE & fe_ff[ACP_DLL_OFF_POS];
    n_az  = fe_ff[ACP_AUTO_ZERO_ENABLE_POS];
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d_ff                 <= 1'b0;
      sen_n_d_ff                <= 1'b0;
      pin_d_ff                  <= 1'b0;
      align_prev_ff             <= 1'b0;
      global_sleep              <= 1'b0;
      clock_buffer_off          <= 1'b0;
      reference_amp_off         <= 1'b0;
      bandgap_off               <= 1'b0;
      align_cmd                 <= 1'b0;
      reference_select          <= ACP_REF_INTERNAL;
      single_ended_clock_select <= 1'b0;
      single_ended_input_chan_a <= 1'b0;
      single_ended_input_chan_b <= 1'b0;
      sampling_delay_loop_off   <= 1'b0;
      auto_zero_enable          <= FE_RST[ACP_AUTO_ZERO_ENABLE_POS];
    end else begin
      sclk_d_ff                 <= nxt_sclk_d;
      sen_n_d_ff                <= nxt_sen_n_d;
      pin_d_ff                  <= nxt_pin_d;
      align_prev_ff             <= nxt_align_prev;
      global_sleep              <= n_sleep;
      clock_buffer_off          <= n_clkoff;
      reference_amp_off         <= n_refoff;
      bandgap_off               <= n_bgoff;
      align_cmd                 <= n_align;
      reference_select          <= n_ref;
      single_ended_clock_select <= n_sec;
      single_ended_input_chan_a <= n_sea;
      single_ended_input_chan_b <= n_seb;
      sampling_delay_loop_off   <= n_dll;
      auto_zero_enable          <= n_az;
    end
  end

  // ==========================================================================
  // checks
  AST_CLKBUF_SLEEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (n_sleep && !mask_ff[ACP_KEEP_CLKBUF_POS]) |=> clock_buffer_off)
    else $error("clock buffer not off in global sleep");
  AST_REFAMP_MASK: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!n_sleep || mask_ff[ACP_KEEP_REFAMP_POS]) |=> !reference_amp_off)
    else $error("reference amplifier off while masked");
  AST_BANDGAP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    1'b1 |=> (bandgap_off == ($past(n_sleep) && $past(mask_ff[ACP_BG_OFF_POS]))))
    else $error("bandgap control wrong");
  AST_PIN_SLEEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_s && !align_ff[ACP_PIN_ALIGN_POS] && !align_ff[ACP_REG_ALIGN_EN]) |=> (global_sleep && !align_cmd))
    else $error("pin high in sleep role did not sleep");
  AST_REG_ALIGN: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (align_ff[ACP_REG_ALIGN_EN] && $changed(align_ff[ACP_REG_ALIGN_POS])) |=> align_cmd)
    else $error("register alignment toggle lost");
  AST_ALIGN_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !wr_commit |=> $stable(align_ff))
    else $error("control register changed without a write");
  AST_PIN_IGNORED: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (align_ff[ACP_REG_ALIGN_EN] && $stable(align_ff[ACP_REG_ALIGN_POS])) |=> !align_cmd)
    else $error("alignment issued while register owns alignment");
  AST_REF_SEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
    align_ff[ACP_REFERENCE_REGISTER_CONTROL_POS] |=> reference_select == $past(align_ff[2:1]))
    else $error("reference select not taken from register");
  AST_SE_CLK: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !align_ff[ACP_REFERENCE_REGISTER_CONTROL_POS] |=> !single_ended_clock_select)
    else $error("single-ended clock without register control");
  AST_FE_WRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (wr_commit && hdr_ff[6:0] == ACP_ADDR_FE_OPT) |=> fe_ff == $past(rx_byte) ##1
    (single_ended_input_chan_a == fe_ff[ACP_SE_A_POS]))
    else $error("front-end write not stored or not applied");

endmodule

`default_nettype wire

// *** acp_pkg.sv ***
// acp_pkg: constants for the converter configuration registers (power-down mask,
// alignment/reference/clock control, front-end options) and their serial port.
// assumes a single 10 MHz system clock; serial pins are oversampled by that clock.
package acp_pkg;

  // ==========================================================================
  // serial frame layout
  localparam int unsigned ACP_HDR_BITS   = 8;            // read flag + 7-bit address
  localparam int unsigned ACP_DATA_BITS  = 8;
  localparam logic [3:0]  ACP_LAST_BIT   = 4'h7;         // index of last bit in a byte
  localparam int unsigned ACP_RW_POS     = 7;            // header bit: 1 = read

  // ==========================================================================
  // register offsets
  localparam logic [6:0]  ACP_ADDR_PDN_MASK  = 7'h0D;
  localparam logic [6:0]  ACP_ADDR_ALIGN_CTL = 7'h0E;
  localparam logic [6:0]  ACP_ADDR_FE_OPT    = 7'h11;

  // ==========================================================================
  // global_powerdown_mask fields
  localparam int unsigned ACP_KEEP_CLKBUF_POS = 3;
  localparam int unsigned ACP_KEEP_REFAMP_POS = 2;
  localparam int unsigned ACP_BG_OFF_POS      = 1;

  // align_reference_clock_control fields
  localparam int unsigned ACP_PIN_ALIGN_POS   = 7;
  localparam int unsigned ACP_REG_ALIGN_POS   = 6;
  localparam int unsigned ACP_REG_ALIGN_EN    = 5;
  localparam int unsigned ACP_REFERENCE_REGISTER_CONTROL_POS     = 3;
  localparam int unsigned ACP_REF_SEL_HI      = 2;
  localparam int unsigned ACP_REF_SEL_LO      = 1;
  localparam int unsigned ACP_SE_CLK_POS      = 0;

  // front_end_options fields
  localparam int unsigned ACP_SE_A_POS        = 5;
  localparam int unsigned ACP_SE_B_POS        = 4;
  localparam int unsigned ACP_DLL_OFF_POS     = 2;
  localparam int unsigned ACP_AUTO_ZERO_ENABLE_POS       = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  ACP_RST_PDN_MASK    = 8'h00;
  localparam logic [7:0]  ACP_RST_ALIGN_CTL   = 8'h00;
  localparam logic [7:0]  ACP_RST_FE_OPT_FAST = 8'h00;   // fastest grade: auto-zero off
  localparam logic [7:0]  ACP_RST_FE_OPT_SLOW = 8'h01;   // slower grades: auto-zero on

  // ==========================================================================
  // reference source codes
  localparam logic [1:0]  ACP_REF_INTERNAL    = 2'h0;
  localparam logic [1:0]  ACP_REF_EXT_BUFFER  = 2'h1;
  localparam logic [1:0]  ACP_REF_EXT_DIRECT  = 2'h2;

  // ==========================================================================
  // serial receiver states
  typedef enum logic [2:0] {
    ACP_ST_IDLE = 3'h1,
    ACP_ST_HDR  = 3'h2,
    ACP_ST_DATA = 3'h4
  } acp_spi_state_e;

endpackage

// *** acp_sync2.sv ***
// acp_sync2: two-flop synchroniser for a bundle of asynchronous pins.
// assumes each bit is an independent level; no bus coherence is offered.
`timescale 1ns/100ps
`default_nettype none

module acp_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // ==========================================================================
  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

`default_nettype wire

// *** acp_host_model.sv ***
// acp_host_model: behavioural host on the serial configuration port.
// assumes the bench clock; pins change only just after its rising edge.
`timescale 1ns/100ps
`default_nettype none

module acp_host_model #(
  parameter int HALF = 6
) (
  // clock
  input  wire logic sys_clk,
  // serial pins
  output var logic  cfg_sclk,
  output var logic  cfg_sen_n,
  output var logic  cfg_sdin,
  input  wire logic cfg_sdout,
  input  wire logic cfg_sdout_oe
);
  // =========================================================================
  // idle levels: serial clock stands still low between frames
  initial begin
    cfg_sclk  = 1'b0;
    cfg_sen_n = 1'b1;
    cfg_sdin  = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one frame, MSB first; fewer than 16 bits aborts it
  // read bits are taken at each sclk rise, unknown when the device is not driving
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat,
                      input int nbits, output logic [7:0] rdat);
    logic [15:0] word;
    word = {rd, addr, wdat};
    rdat = 8'hXX;
    cfg_sen_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      cfg_sdin <= word[15-i];
      wt(HALF);
      if (i >= 8) rdat = {rdat[6:0], (cfg_sdout_oe === 1'b1) ? cfg_sdout : 1'bx};
      cfg_sclk <= 1'b1;
      wt(HALF);
      cfg_sclk <= 1'b0;
    end
    wt(HALF);
    cfg_sen_n <= 1'b1;
    cfg_sdin  <= ~cfg_sdin;  // no pull on the line: never leave the last bit showing
    wt(2 * HALF);
  endtask
endmodule
`default_nettype wire

// *** test_adc_config_power_align_regs.sv ***
// test_adc_config_power_align_regs: self-checking bench for the configuration registers.
// assumes the fastest grade on u_dut and a slower grade beside it on the same serial port;
// the host model drives the serial port.
`timescale 1ns/100ps
`default_nettype none

module test_adc_config_power_align_regs;
  import acp_pkg::*;
  logic       sys_clk, arst_n, align_or_sleep_pin, reference_buffer_pin, global_sleep_bit;
  logic       cfg_sclk, cfg_sen_n, cfg_sdin, cfg_sdout, cfg_sdout_oe;
  logic       global_sleep, clock_buffer_off, reference_amp_off, bandgap_off, align_cmd;
  logic [1:0] reference_select;
  logic       single_ended_clock_select, single_ended_input_chan_a, single_ended_input_chan_b;
  logic       sampling_delay_loop_off, auto_zero_enable;
  logic       slow_az, slow_dll;
  int         fails, n_checks, n_align, cyc;

  // =========================================================================
  // design and host
  acp_config_regs #(.FASTEST_GRADE(1'b1)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .cfg_sclk(cfg_sclk), .cfg_sen_n(cfg_sen_n), .cfg_sdin(cfg_sdin), .cfg_sdout(cfg_sdout),
    .cfg_sdout_oe(cfg_sdout_oe), .align_or_sleep_pin(align_or_sleep_pin),
    .reference_buffer_pin(reference_buffer_pin), .global_sleep_bit(global_sleep_bit),
    .global_sleep(global_sleep), .clock_buffer_off(clock_buffer_off),
    .reference_amp_off(reference_amp_off), .bandgap_off(bandgap_off), .align_cmd(align_cmd),
    .reference_select(reference_select), .single_ended_clock_select(single_ended_clock_select),
    .single_ended_input_chan_a(single_ended_input_chan_a),
    .single_ended_input_chan_b(single_ended_input_chan_b),
    .sampling_delay_loop_off(sampling_delay_loop_off), .auto_zero_enable(auto_zero_enable));
  acp_host_model u_host (.sys_clk(sys_clk), .cfg_sclk(cfg_sclk), .cfg_sen_n(cfg_sen_n),
    .cfg_sdin(cfg_sdin), .cfg_sdout(cfg_sdout), .cfg_sdout_oe(cfg_sdout_oe));
  // slower grade listens to every frame; only its grade-dependent outputs are watched
  acp_config_regs #(.FASTEST_GRADE(1'b0)) u_dut_slow (.sys_clk(sys_clk), .arst_n(arst_n),
    .cfg_sclk(cfg_sclk), .cfg_sen_n(cfg_sen_n), .cfg_sdin(cfg_sdin), .cfg_sdout(),
    .cfg_sdout_oe(), .align_or_sleep_pin(align_or_sleep_pin),
    .reference_buffer_pin(reference_buffer_pin), .global_sleep_bit(global_sleep_bit),
    .global_sleep(), .clock_buffer_off(), .reference_amp_off(), .bandgap_off(),
    .align_cmd(), .reference_select(), .single_ended_clock_select(),
    .single_ended_input_chan_a(), .single_ended_input_chan_b(),
    .sampling_delay_loop_off(slow_dll), .auto_zero_enable(slow_az));

  // =========================================================================
  // clock, alignment pulse counter, hang guard (about 10k cycles expected)
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (align_cmd === 1'b1) n_align <= n_align + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // =========================================================================
  // compare tasks
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected register value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected output level at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // register access; outputs have settled when the frame returns
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_host.xfer(1'b0, a, d, 16, r);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] r;
    u_host.xfer(1'b1, a, 8'h00, 16, r);
    chk_reg(r, exp);
  endtask

  // =========================================================================
  // scenarios
  task automatic t_reset();
    chk_out({global_sleep, auto_zero_enable}, 2'h0);
    chk_out({slow_az, slow_dll}, {ACP_RST_FE_OPT_SLOW[ACP_AUTO_ZERO_ENABLE_POS], 1'b0});
    rd_chk(ACP_ADDR_PDN_MASK, ACP_RST_PDN_MASK);
    rd_chk(ACP_ADDR_ALIGN_CTL, ACP_RST_ALIGN_CTL);
    rd_chk(ACP_ADDR_FE_OPT, ACP_RST_FE_OPT_FAST);
  endtask

  // every mask combination under register sleep, then pin sleep
  task automatic t_mask();
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'(i << 1);
      wr(ACP_ADDR_PDN_MASK, m);
      rd_chk(ACP_ADDR_PDN_MASK, m);
      global_sleep_bit <= 1'b1;
      step(4);
      chk_out({clock_buffer_off, global_sleep}, {~m[3], 1'b1});
      chk_out({reference_amp_off, 1'b0}, {~m[2], 1'b0});
      chk_out({bandgap_off, 1'b0}, {m[1], 1'b0});
      global_sleep_bit <= 1'b0;
      step(4);
      chk_out({clock_buffer_off, bandgap_off}, 2'h0);
    end
    align_or_sleep_pin <= 1'b1;
    step(5);
    chk_out({global_sleep, bandgap_off}, 2'h3);
    chk_out({clock_buffer_off, reference_amp_off}, 2'h0);
    align_or_sleep_pin <= 1'b0;
    step(5);
  endtask

  task automatic pin_pulse();
    align_or_sleep_pin <= 1'b1;
    step(6);
    chk_out({global_sleep, 1'b0}, 2'h0);
    align_or_sleep_pin <= 1'b0;
    step(6);
  endtask

  // pin alignment, then register command bit toggled both ways
  task automatic t_align();
    int n0;
    n0 = n_align;
    wr(ACP_ADDR_ALIGN_CTL, 8'h80);
    pin_pulse();
    chk_out(2'(n_align - n0), 2'h1);
    wr(ACP_ADDR_ALIGN_CTL, 8'hA0);
    wr(ACP_ADDR_ALIGN_CTL, 8'hE0);
    rd_chk(ACP_ADDR_ALIGN_CTL, 8'hE0);
    pin_pulse();
    chk_out(2'(n_align - n0), 2'h2);
    wr(ACP_ADDR_ALIGN_CTL, 8'hA0);
    chk_out(2'(n_align - n0), 2'h3);
    wr(ACP_ADDR_ALIGN_CTL, 8'h80);
    wr(ACP_ADDR_ALIGN_CTL, 8'hC0);
    chk_out(2'(n_align - n0), 2'h3);
  endtask

  task automatic t_ref();
    wr(ACP_ADDR_ALIGN_CTL, 8'h00);
    for (int p = 0; p < 2; p++) begin
      reference_buffer_pin <= p[0];
      step(5);
      chk_out(reference_select, p[0] ? ACP_REF_EXT_BUFFER : ACP_REF_INTERNAL);
    end
    // pin left high: register control has to override it
    for (int c = 0; c < 4; c++) begin
      wr(ACP_ADDR_ALIGN_CTL, 8'h08 | 8'(c << 1));
      chk_out(reference_select, 2'(c));
    end
    wr(ACP_ADDR_ALIGN_CTL, 8'h01);
    chk_out({single_ended_clock_select, clock_buffer_off}, 2'h0);
    wr(ACP_ADDR_ALIGN_CTL, 8'h09);
    chk_out({single_ended_clock_select, clock_buffer_off}, 2'h3);
    rd_chk(ACP_ADDR_ALIGN_CTL, 8'h09);
    reference_buffer_pin <= 1'b0;
  endtask

  // one option bit at a time so that swapped bits show; rate assumed below 40 MSPS
  task automatic t_fe();
    logic [7:0] v;
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : (i == 2) ? 8'h04 : 8'h01;
      wr(ACP_ADDR_FE_OPT, v);
      chk_out({single_ended_input_chan_a, 1'b0}, {v[5], 1'b0});
      chk_out({single_ended_input_chan_b, 1'b0}, {v[4], 1'b0});
      chk_out({sampling_delay_loop_off, 1'b0}, {v[2], 1'b0});
      chk_out({auto_zero_enable, 1'b0}, {v[0], 1'b0});
      chk_out({slow_dll, slow_az}, {1'b0, v[0]});
      rd_chk(ACP_ADDR_FE_OPT, v);
    end
    u_host.xfer(1'b0, ACP_ADDR_FE_OPT, 8'h34, 10, r);
    rd_chk(ACP_ADDR_FE_OPT, 8'h01);
    rd_chk(7'h12, 8'h00);
  endtask

  task automatic t_second_reset();
    arst_n <= 1'b0;
    step(2);
    arst_n <= 1'b1;
    step(4);
    chk_out({auto_zero_enable, single_ended_clock_select}, 2'h0);
    chk_out({slow_az, slow_dll}, {ACP_RST_FE_OPT_SLOW[ACP_AUTO_ZERO_ENABLE_POS], 1'b0});
    rd_chk(ACP_ADDR_FE_OPT, ACP_RST_FE_OPT_FAST);
    rd_chk(ACP_ADDR_ALIGN_CTL, ACP_RST_ALIGN_CTL);
  endtask

  // =========================================================================
  // main sequence
  initial begin
    sys_clk              = 1'b0;
    arst_n               = 1'b0;
    align_or_sleep_pin   = 1'b0;
    reference_buffer_pin = 1'b0;
    global_sleep_bit     = 1'b0;
    fails                = 0;
    n_checks             = 0;
    n_align              = 0;
    cyc                  = 0;
    step(2);
    arst_n <= 1'b1;
    step(4);
    t_reset();
    t_mask();
    t_align();
    t_ref();
    t_fe();
    t_second_reset();
    conclude();
  end
endmodule
`default_nettype wire
